// file: src/asr_pkg.sv
package asr_pkg;
    localparam int DATA_BITS = 18;
    localparam int CLK_NS = 25;
    // converter timing; the device model sits between the host's limits
    localparam int CONV_TIME_NS = 1200;
    localparam int CONV_MIN_NS = 1000;
    localparam int CONV_MAX_NS = 1400;
    localparam int CONV_CYC = CONV_TIME_NS / CLK_NS;
    // least time of a deadline rounds down, a wait rounds up
    localparam int CONV_MIN_CYC = CONV_MIN_NS / CLK_NS;
    localparam int CONV_MAX_CYC = (CONV_MAX_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_MARGIN_CYC = 8;
    localparam int STEP_CYC = 8;
    localparam int HOLD_CYC = 8;
    localparam int SCLK_HALF_CYC = 8;
    localparam int FIFO_DEPTH = 2;
    localparam int PIN_CONV = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_SIN = 2;
    localparam logic [2:0] PIN_IDLE = 3'h5;

    typedef enum logic [1:0] {
        DEV_ACQ = 2'h0,
        DEV_CONV = 2'h1,
        DEV_WAIT = 2'h3,
        DEV_READ = 2'h2
    } asr_dev_state_t;

    typedef enum logic [2:0] {
        HST_IDLE = 3'h0,
        HST_PRE = 3'h1,
        HST_CONV = 3'h3,
        HST_WAIT = 3'h2,
        HST_CLK = 3'h6,
        HST_END = 3'h7,
        HST_PWR = 3'h4
    } asr_hst_state_t;
endpackage

// file: src/asr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface asr_link_if;
    logic convStart;
    logic serialClock;
    logic serialIn;
    logic serialOut;
    logic serialOutEn;
    logic serialOutLine;
    // a released serial_out is pulled up to the io_supply level
    assign serialOutLine = serialOutEn ? serialOut : 1'h1;
    modport device (
        input convStart, serialClock, serialIn,
        output serialOut, serialOutEn
    );
    modport host (
        output convStart, serialClock, serialIn,
        input serialOutLine
    );
endinterface
`default_nettype wire

// file: src/asr_device.sv
// Notes on behaviour
// - clock high at start fall: enter shutdown
// - clock low at start fall: leave shutdown
// - rise with serial_in high starts conversion
// - conversion ignores convert_start once started
// - host: 3-wire no-busy, start high throughout conversion
// - 3-wire no-busy: start low shows MSB
// - no-busy: release after 18 falls or rise
// - host: 3-wire busy, start low until busy
// - busy modes: drive low at completion
// - busy modes: MSB first, release after 19
// - host: 4-wire keeps start high throughout
// - start and serial_in low: drive low
// - host: 4-wire no-busy, serial_in high meanwhile
// - host: 4-wire busy, serial_in low until busy
// - 4-wire no-busy: serial_in low shows MSB
// - either line low at completion: busy on
// - host: no-busy waits maximum conversion time
// - data bit held over the rise, moved on each fall
`timescale 1ns/1ps
`default_nettype none
module asr_device #(
    parameter int DataBits = asr_pkg::DATA_BITS, // result width
    parameter int ConvCyc = asr_pkg::CONV_CYC // conversion length
) (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous, active high
    asr_link_if.device link, // serial link pins
    input wire logic [DataBits-1:0] sampleData, // conversion result
    output logic converting, // conversion running
    output logic inShutdown, // powered down
    output logic resultLoaded // pulse at conversion completion
);
    localparam int SW = DataBits + 1;
    localparam int CW = $clog2(ConvCyc);
    localparam int FW = $clog2(DataBits + 2);

    if (DataBits < 2 || ConvCyc < asr_pkg::CONV_MIN_CYC ||
        ConvCyc > asr_pkg::CONV_MAX_CYC) begin : g_bad_param
        $error("asr_device: unsupported parameter values");
    end

    logic [2:0] pinIn;
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] sync3_ff;
    logic [2:0] level_ff;
    logic [2:0] settled;
    logic [2:0] rise;
    logic [2:0] fall;
    logic csLvl;
    logic siLvl;
    logic sclkLvl;
    logic csRise;
    logic csFall;
    logic sclkFall;
    logic convDone;
    logic busyNow;
    logic lastFall;
    logic shutdown_ff;
    logic busyMode_ff;
    logic [CW-1:0] convCnt_ff;
    logic [FW-1:0] fallCnt_ff;
    logic [SW-1:0] shift_ff;
    asr_pkg::asr_dev_state_t state_ff;

    assign pinIn[asr_pkg::PIN_CONV] = link.convStart;
    assign pinIn[asr_pkg::PIN_SCLK] = link.serialClock;
    assign pinIn[asr_pkg::PIN_SIN] = link.serialIn;

    for (genvar i = 0; i < 3; i++) begin : g_sync
        // first stage feeds only the second; stages two and three vote
        always_ff @(posedge clk) begin
            if (reset) begin
                sync1_ff[i] <= asr_pkg::PIN_IDLE[i];
                sync2_ff[i] <= asr_pkg::PIN_IDLE[i];
                sync3_ff[i] <= asr_pkg::PIN_IDLE[i];
                level_ff[i] <= asr_pkg::PIN_IDLE[i];
            end else begin
                sync1_ff[i] <= pinIn[i];
                sync2_ff[i] <= sync1_ff[i];
                sync3_ff[i] <= sync2_ff[i];
                if (settled[i]) begin
                    level_ff[i] <= sync3_ff[i];
                end
            end
        end
        assign settled[i] = sync2_ff[i] == sync3_ff[i];
        assign rise[i] = settled[i] && sync3_ff[i] && !level_ff[i];
        assign fall[i] = settled[i] && !sync3_ff[i] && level_ff[i];
    end

    assign csLvl = level_ff[asr_pkg::PIN_CONV];
    assign siLvl = level_ff[asr_pkg::PIN_SIN];
    assign sclkLvl = level_ff[asr_pkg::PIN_SCLK];
    assign csRise = rise[asr_pkg::PIN_CONV];
    assign csFall = fall[asr_pkg::PIN_CONV];
    assign sclkFall = fall[asr_pkg::PIN_SCLK];

    assign convDone = state_ff == asr_pkg::DEV_CONV &&
                      convCnt_ff == CW'(ConvCyc - 1);
    assign busyNow = !csLvl || !siLvl;
    // the 18th fall ends plain readout; the 19th when a busy bit led
    assign lastFall = sclkFall &&
                      fallCnt_ff == (busyMode_ff ? FW'(DataBits) :
                                     FW'(DataBits - 1));

    // power state follows the clock level at every start fall
    always_ff @(posedge clk) begin
        if (reset) begin
            shutdown_ff <= 1'h0;
        end else if (csFall) begin
            shutdown_ff <= sclkLvl;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || shutdown_ff) begin
            state_ff <= asr_pkg::DEV_ACQ;
        end else begin
            unique case (state_ff)
                asr_pkg::DEV_ACQ: begin
                    // serial_in low at the rise would pick the chain
                    // mode, which this block does not serve: ignored
                    if (csRise && siLvl) begin
                        state_ff <= asr_pkg::DEV_CONV;
                    end
                end
                asr_pkg::DEV_CONV: begin
                    // start edges are not looked at here
                    if (convDone) begin
                        if (busyNow) begin
                            state_ff <= asr_pkg::DEV_READ;
                        end else begin
                            state_ff <= asr_pkg::DEV_WAIT;
                        end
                    end
                end
                asr_pkg::DEV_WAIT: begin
                    if (csRise) begin
                        state_ff <= siLvl ? asr_pkg::DEV_CONV :
                                    asr_pkg::DEV_ACQ;
                    end else if (!csLvl || !siLvl) begin
                        state_ff <= asr_pkg::DEV_READ;
                    end
                end
                asr_pkg::DEV_READ: begin
                    if (csRise) begin
                        state_ff <= siLvl ? asr_pkg::DEV_CONV :
                                    asr_pkg::DEV_ACQ;
                    end else if (lastFall) begin
                        state_ff <= asr_pkg::DEV_ACQ;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset || state_ff != asr_pkg::DEV_CONV) begin
            convCnt_ff <= '0;
        end else begin
            convCnt_ff <= convCnt_ff + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            busyMode_ff <= 1'h0;
        end else if (convDone) begin
            busyMode_ff <= busyNow;
        end
    end

    // a busy readout carries a leading zero that the first fall flushes
    always_ff @(posedge clk) begin
        if (reset) begin
            shift_ff <= '0;
        end else if (convDone) begin
            if (busyNow) begin
                shift_ff <= {1'h0, sampleData};
            end else begin
                shift_ff <= {sampleData, 1'h0};
            end
        end else if (state_ff == asr_pkg::DEV_READ && sclkFall) begin
            // bits move only on falls, so each stands a whole period
            shift_ff <= {shift_ff[SW-2:0], 1'h0};
        end
    end

    always_ff @(posedge clk) begin
        if (reset || convDone) begin
            fallCnt_ff <= '0;
        end else if (state_ff == asr_pkg::DEV_READ && sclkFall) begin
            fallCnt_ff <= fallCnt_ff + FW'(1);
        end
    end

    // released except while reading, or while both inputs are low
    assign link.serialOutEn = state_ff == asr_pkg::DEV_READ ||
                              (!csLvl && !siLvl);
    assign link.serialOut = state_ff == asr_pkg::DEV_READ ?
                            shift_ff[SW-1] : 1'h0;
    assign converting = state_ff == asr_pkg::DEV_CONV;
    assign inShutdown = shutdown_ff;
    assign resultLoaded = convDone;
endmodule
`default_nettype wire

// file: src/asr_host.sv
`timescale 1ns/1ps
`default_nettype none
module asr_host #(
    parameter int DataBits = asr_pkg::DATA_BITS, // word width
    parameter int Depth = asr_pkg::FIFO_DEPTH // word buffer entries
) (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous, active high
    asr_link_if.host link, // serial link pins
    input wire logic fourWire, // 1: serial_in selects readout
    input wire logic useBusy, // 1: wait for busy indication
    input wire logic startValid, // request one conversion
    output logic startReady, // conversion request taken
    input wire logic pwrValid, // request a power change
    input wire logic pwrDown, // 1: shutdown, 0: wake
    output logic pwrReady, // power request taken
    output logic wordValid, // buffered word available
    input wire logic wordReady, // consumer takes the word
    output logic [DataBits-1:0] wordData // oldest buffered word
);
    localparam int PW = Depth > 1 ? $clog2(Depth) : 1;
    localparam int TW = 8;
    localparam int NW = $clog2(DataBits + 2);
    localparam int WAIT_CYC = asr_pkg::CONV_MAX_CYC +
                              asr_pkg::SYNC_MARGIN_CYC;

    if (Depth < 2 || DataBits < 2 || WAIT_CYC >= 2 ** TW ||
        asr_pkg::HOLD_CYC >= asr_pkg::CONV_MIN_CYC) begin : g_bad_param
        $error("asr_host: unsupported parameter values");
    end

    asr_pkg::asr_hst_state_t state_ff;
    logic [TW-1:0] tim_ff;
    logic [NW-1:0] nf_ff;
    logic cs_ff;
    logic si_ff;
    logic sclk_ff;
    logic push_ff;
    logic sdo1_ff;
    logic sdo2_ff;
    logic sdo3_ff;
    logic sdoLvl_ff;
    logic [DataBits-1:0] acc_ff;
    logic [DataBits-1:0] mem_ff [Depth];
    logic [PW-1:0] wrPtr_ff;
    logic [PW-1:0] rdPtr_ff;
    logic [PW:0] cnt_ff;
    logic full;
    logic pop;
    logic lastHalf;

    assign full = cnt_ff == (PW + 1)'(Depth);
    assign pop = wordValid && wordReady;
    assign lastHalf = tim_ff == TW'(asr_pkg::SCLK_HALF_CYC - 1);
    // a full buffer holds off the next conversion, so no word is lost
    assign startReady = state_ff == asr_pkg::HST_IDLE && !full;
    assign pwrReady = state_ff == asr_pkg::HST_IDLE && !startValid;

    always_ff @(posedge clk) begin
        if (reset) begin
            sdo1_ff <= 1'h1;
            sdo2_ff <= 1'h1;
            sdo3_ff <= 1'h1;
            sdoLvl_ff <= 1'h1;
        end else begin
            sdo1_ff <= link.serialOutLine;
            sdo2_ff <= sdo1_ff;
            sdo3_ff <= sdo2_ff;
            if (sdo2_ff == sdo3_ff) begin
                sdoLvl_ff <= sdo3_ff;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= asr_pkg::HST_IDLE;
            tim_ff <= '0;
            nf_ff <= '0;
            cs_ff <= 1'h1;
            si_ff <= 1'h1;
            sclk_ff <= 1'h0;
            push_ff <= 1'h0;
        end else begin
            tim_ff <= tim_ff + TW'(1);
            push_ff <= 1'h0;
            unique case (state_ff)
                asr_pkg::HST_IDLE: begin
                    tim_ff <= '0;
                    if (startValid && !full) begin
                        cs_ff <= 1'h0; // low clock: also a wake
                        state_ff <= asr_pkg::HST_PRE;
                    end else if (pwrValid) begin
                        sclk_ff <= pwrDown;
                        si_ff <= 1'h0;
                        state_ff <= asr_pkg::HST_PWR;
                    end
                end
                asr_pkg::HST_PRE: begin
                    if (tim_ff == TW'(asr_pkg::STEP_CYC)) begin
                        cs_ff <= 1'h1; // serial_in high: select mode
                        tim_ff <= '0;
                        state_ff <= asr_pkg::HST_CONV;
                    end
                end
                asr_pkg::HST_CONV: begin
                    if (useBusy && tim_ff == TW'(asr_pkg::HOLD_CYC)) begin
                        if (fourWire) begin
                            si_ff <= 1'h0;
                        end else begin
                            cs_ff <= 1'h0;
                        end
                        tim_ff <= '0;
                        state_ff <= asr_pkg::HST_WAIT;
                    end else if (!useBusy && tim_ff == TW'(WAIT_CYC)) begin
                        // held high up to here, past the longest conversion
                        if (fourWire) begin
                            si_ff <= 1'h0;
                        end else begin
                            cs_ff <= 1'h0;
                        end
                        tim_ff <= '0;
                        state_ff <= asr_pkg::HST_WAIT;
                    end
                end
                asr_pkg::HST_WAIT: begin
                    if (useBusy ? !sdoLvl_ff :
                        tim_ff == TW'(asr_pkg::STEP_CYC)) begin
                        tim_ff <= '0;
                        nf_ff <= '0;
                        state_ff <= asr_pkg::HST_CLK;
                    end
                end
                asr_pkg::HST_CLK: begin
                    if (lastHalf) begin
                        tim_ff <= '0;
                        sclk_ff <= !sclk_ff;
                        if (sclk_ff) begin
                            nf_ff <= nf_ff + NW'(1);
                            if (nf_ff == NW'(useBusy ? DataBits :
                                              DataBits - 1)) begin
                                si_ff <= fourWire;
                                push_ff <= 1'h1;
                                state_ff <= asr_pkg::HST_END;
                            end
                        end
                    end
                end
                asr_pkg::HST_END: begin
                    // 3-wire: the closing rise has serial_in low, so
                    // the device takes it for no new conversion
                    if (tim_ff == TW'(asr_pkg::STEP_CYC)) begin
                        cs_ff <= 1'h1;
                    end else if (tim_ff == TW'(2 * asr_pkg::STEP_CYC)) begin
                        si_ff <= 1'h1;
                        state_ff <= asr_pkg::HST_IDLE;
                    end
                end
                asr_pkg::HST_PWR: begin
                    if (tim_ff == TW'(asr_pkg::STEP_CYC)) begin
                        cs_ff <= 1'h0;
                    end else if (tim_ff == TW'(2 * asr_pkg::STEP_CYC)) begin
                        cs_ff <= 1'h1;
                    end else if (tim_ff == TW'(3 * asr_pkg::STEP_CYC)) begin
                        si_ff <= 1'h1;
                        sclk_ff <= 1'h0;
                        state_ff <= asr_pkg::HST_IDLE;
                    end
                end
                default: begin
                    state_ff <= asr_pkg::HST_IDLE;
                end
            endcase
        end
    end

    // sample just before each fall; a busy readout skips the first bit
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_ff <= '0;
        end else if (state_ff == asr_pkg::HST_CLK && lastHalf &&
                     sclk_ff && (!useBusy || nf_ff != '0)) begin
            acc_ff <= {acc_ff[DataBits-2:0], sdoLvl_ff};
        end
    end

    always_ff @(posedge clk) begin
        if (push_ff) begin
            mem_ff[wrPtr_ff] <= acc_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push_ff) begin
                wrPtr_ff <= wrPtr_ff == PW'(Depth - 1) ? '0 :
                            wrPtr_ff + PW'(1);
            end
            if (pop) begin
                rdPtr_ff <= rdPtr_ff == PW'(Depth - 1) ? '0 :
                            rdPtr_ff + PW'(1);
            end
            cnt_ff <= cnt_ff + (PW + 1)'(push_ff) - (PW + 1)'(pop);
        end
    end

    assign wordValid = cnt_ff != '0;
    assign wordData = mem_ff[rdPtr_ff];
    assign link.convStart = cs_ff;
    assign link.serialIn = si_ff;
    assign link.serialClock = sclk_ff;
endmodule
`default_nettype wire

// file: tb/asr_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module asr_link_props #(
    parameter int ConvCyc = asr_pkg::CONV_CYC // conversion length
) (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic convStart, // host start line
    input wire logic serialClock, // host link clock
    input wire logic serialIn, // host select line
    input wire logic serialOut, // device data bit
    input wire logic serialOutEn, // device drive enable
    input wire logic serialOutLine // resolved line
);
    // ages count from the start rise on the pins, ahead of the sync stages
    localparam logic [7:0] QUIET_END = 8'(ConvCyc - 4);
    localparam logic [7:0] BUSY_AGE = 8'(ConvCyc + 6);
    localparam logic [7:0] READ_END = 8'(ConvCyc + 72);
    logic [7:0] convAge_ff;
    logic [4:0] fallCnt_ff;
    logic [3:0] sinceFall_ff;
    logic clkPrev_ff;
    logic fallSeen;

    assign fallSeen = clkPrev_ff && !serialClock;
    always_ff @(posedge clk) begin
        if (reset) clkPrev_ff <= 1'h0;
        else clkPrev_ff <= serialClock;
    end
    always_ff @(posedge clk) begin
        if (reset) convAge_ff <= 8'hFF;
        else if ($rose(convStart) && serialIn) convAge_ff <= 8'h00;
        else if (convAge_ff != 8'hFF) convAge_ff <= convAge_ff + 8'h01;
    end
    // falls are only counted while the device drives the line
    always_ff @(posedge clk) begin
        if (reset || !serialOutEn) fallCnt_ff <= 5'h00;
        else if (fallSeen && fallCnt_ff != 5'h1F)
            fallCnt_ff <= fallCnt_ff + 5'h01;
    end
    always_ff @(posedge clk) begin
        if (reset) sinceFall_ff <= 4'hF;
        else if (fallSeen) sinceFall_ff <= 4'h0;
        else if (sinceFall_ff != 4'hF) sinceFall_ff <= sinceFall_ff + 4'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_select_low_drive: assert property (
        (!convStart && !serialIn) [*6] |-> serialOutEn)
        else $error("line not driven while both selects low");
    a_rise_release: assert property (
        $rose(convStart) |-> ##[1:6] !serialOutEn)
        else $error("line still driven after start rise");
    a_conv_quiet: assert property (
        convAge_ff >= 8'h08 && convAge_ff <= QUIET_END
        && (convStart || serialIn) |-> !serialOutEn)
        else $error("line driven during conversion");
    a_busy_low: assert property (
        convAge_ff == BUSY_AGE && (!convStart || !serialIn)
        |-> serialOutEn && !serialOut)
        else $error("busy level missing at completion");
    a_msb_shown: assert property (
        convAge_ff >= BUSY_AGE && convAge_ff <= READ_END
        && (($fell(convStart) && serialIn && !serialClock)
        || ($fell(serialIn) && convStart)) |-> ##[2:6] serialOutEn)
        else $error("readout select did not drive the line");
    a_release_count: assert property (
        fallCnt_ff == 5'h13 && (convStart || serialIn)
        |-> ##[0:6] !serialOutEn)
        else $error("line driven past the last fall");
    a_bit_hold: assert property (
        serialOutEn && $past(serialOutEn) && serialClock
        && $past(serialClock) && (convStart || serialIn)
        |-> $stable(serialOutLine))
        else $error("data bit moved while clock high");
    a_bit_moves: assert property (
        serialOutEn && $past(serialOutEn) && $past(serialOutEn, 3)
        && (convStart || serialIn) && $past(convStart || serialIn)
        && $changed(serialOutLine) |-> sinceFall_ff <= 4'h7)
        else $error("data bit moved without a clock fall");

    c_busy_seen: cover property (convAge_ff == BUSY_AGE && serialOutEn);
    c_full_read: cover property (fallCnt_ff == 5'h13);
    c_both_low: cover property ((!convStart && !serialIn) [*6]);
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int W = asr_pkg::DATA_BITS;
    logic clk, reset, fourWire, useBusy, startValid, startReady;
    logic pwrValid, pwrDown, pwrReady, wordValid, wordReady;
    logic converting, inShutdown, resultLoaded, convB, shutB;
    logic [W-1:0] wordData, sampleData, sampleDataB;
    logic [W-1:0] expQ[$];
    logic [W-1:0] corner[4] = '{18'h3FFFF, 18'h00000, 18'h2AAAA, 18'h15555};
    int failures, n_tests, seed, convCount, t;
    int loadCount, convCycA, nRuns;

    asr_link_if link();
    asr_link_if linkB();
    asr_device u_asr_device (.clk(clk), .reset(reset), .link(link),
        .sampleData(sampleData), .converting(converting),
        .inShutdown(inShutdown), .resultLoaded(resultLoaded));
    asr_host u_asr_host (.clk(clk), .reset(reset), .link(link),
        .fourWire(fourWire), .useBusy(useBusy), .startValid(startValid),
        .startReady(startReady), .pwrValid(pwrValid), .pwrDown(pwrDown),
        .pwrReady(pwrReady), .wordValid(wordValid), .wordReady(wordReady),
        .wordData(wordData));
    // second device faces the bench alone, so host misbehaviour can be made
    asr_device u_asr_device_b (.clk(clk), .reset(reset), .link(linkB),
        .sampleData(sampleDataB), .converting(convB), .inShutdown(shutB),
        .resultLoaded());
    asr_link_props #(.ConvCyc(asr_pkg::CONV_CYC)) u_asr_link_props (
        .clk(clk), .reset(reset), .convStart(link.convStart),
        .serialClock(link.serialClock), .serialIn(link.serialIn),
        .serialOut(link.serialOut), .serialOutEn(link.serialOutEn),
        .serialOutLine(link.serialOutLine));

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (convB === 1'h1) convCount++;
    always @(posedge clk) if (resultLoaded === 1'h1) loadCount++;
    always @(posedge clk) if (converting === 1'h1) convCycA++;

    // every started conversion runs its full length, nothing more
    function automatic int conv_cycles(input int runs);
        return runs * asr_pkg::CONV_CYC;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [W-1:0] exp,
                         input logic [W-1:0] seen);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic pins(input logic c, k, s, input int n);
        linkB.convStart = c;
        linkB.serialClock = k;
        linkB.serialIn = s;
        tick(n);
    endtask
    task automatic pwr(input logic dn);
        pwrDown = dn;
        pwrValid = 1'h1;
        do @(posedge clk); while (pwrReady !== 1'h1);
        #1 pwrValid = 1'h0;
        check("pwrReady", '0, W'(pwrReady));
        tick(40);
        check("inShutdown", W'(dn), W'(inShutdown));
    endtask
    // mode is held until the next request, past the word push
    task automatic run_conv(input logic fw, ub, input logic [W-1:0] d,
                            input logic full);
        fourWire = fw;
        useBusy = ub;
        sampleData = d;
        startValid = 1'h1;
        do @(posedge clk); while (startReady !== 1'h1);
        #1 startValid = 1'h0;
        expQ.push_back(d);
        nRuns++;
        for (t = 0; t < 600 && startReady !== 1'h1; t++) @(posedge clk);
        #1 check("startReady", W'(!full), W'(startReady));
    endtask
    task automatic drain();
        for (t = 0; t < 400 && expQ.size() > 0; t++) begin
            wordReady = 1'($random(seed));
            // looked at one step after the edge, where the word has settled
            if (wordValid === 1'h1 && wordReady === 1'h1)
                check("word", expQ.pop_front(), wordData);
            tick(1);
        end
        wordReady = 1'h0;
        check("left", '0, W'(expQ.size()));
        check("wordValid", '0, W'(wordValid));
    endtask
    task automatic side_b();
        logic [W-1:0] rd;
        rd = '0;
        sampleDataB = W'($random(seed));
        convCount = 0;
        pins(1'h0, 1'h0, 1'h1, 8);
        pins(1'h1, 1'h0, 1'h1, 8);
        pins(1'h0, 1'h0, 1'h1, 6); // start dropped and raised mid-run
        pins(1'h1, 1'h0, 1'h1, 6);
        pins(1'h0, 1'h0, 1'h1, 60);
        check("convLen", W'(asr_pkg::CONV_CYC), W'(convCount));
        check("busyLine", '0, W'(linkB.serialOutLine));
        for (int i = 0; i < 19; i++) begin
            pins(1'h0, 1'h1, 1'h1, 4);
            if (i > 0) rd = {rd[W-2:0], linkB.serialOutLine};
            pins(1'h0, 1'h0, 1'h1, 4);
        end
        check("wordB", sampleDataB, rd);
        pins(1'h0, 1'h0, 1'h1, 4);
        check("releasedB", W'(1), W'(linkB.serialOutLine));
        pins(1'h0, 1'h0, 1'h0, 8);
        check("bothLow", '0, W'(linkB.serialOutLine));
        convCount = 0;
        pins(1'h1, 1'h0, 1'h0, 70);
        check("chainRise", '0, W'(convCount));
        pins(1'h1, 1'h1, 1'h1, 8);
        pins(1'h0, 1'h1, 1'h1, 16);
        check("shutB", W'(1), W'(shutB));
        pins(1'h1, 1'h0, 1'h1, 70);
        check("shutRise", '0, W'(convCount));
        pins(1'h0, 1'h0, 1'h1, 16);
        check("wakeB", '0, W'(shutB));
        pins(1'h1, 1'h0, 1'h1, 70);
        check("convB", W'(asr_pkg::CONV_CYC), W'(convCount));
        check("quietB", W'(1), W'(linkB.serialOutLine));
    endtask

    initial begin
        seed = 18518;
        {reset, fourWire, useBusy, startValid, pwrValid, pwrDown} = 6'h20;
        wordReady = 1'h0;
        sampleData = '0;
        sampleDataB = '0;
        convCount = 0;
        pins(1'h1, 1'h0, 1'h1, 20);
        reset = 1'h0;
        tick(2);
        check("idleLine", W'(1), W'(link.serialOutLine));
        pwr(1'h1);
        pwr(1'h0);
        // every mode, corner words, then a second word to fill the buffer
        for (int m = 0; m < 4; m++) begin
            run_conv(m[1], m[0], corner[m], 1'h0);
            run_conv(m[1], m[0], W'($random(seed)), 1'h1);
            drain();
        end
        repeat (6) begin
            run_conv(1'($random(seed)), 1'($random(seed)),
                     W'($random(seed)), 1'h0);
            drain();
        end
        check("loads", W'(nRuns), W'(loadCount));
        check("convCycles", W'(conv_cycles(nRuns)), W'(convCycA));
        side_b();
        give_verdict();
    end
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        give_verdict();
    end
endmodule
`default_nettype wire
